// >>> fcp_cfg.svh
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
// ==========================================
// Timing
`define FCP_CLK_PERIOD_NS 10
`define FCP_SETTLE_UNIT_NS 2000000
`define FCP_RELEASE_UNIT_NS 16000000
// ==========================================
// Sector geometry
`define FCP_SECTOR_BASE 15'h0080
`define FCP_SIZE_CODE_MAX 8'h07
`define FCP_SIZE_CODE_ZERO 8'h00
`define FCP_FIRST_SECTOR 8'h01
`define FCP_HEAD0 1'b0
`define FCP_HEAD1 1'b1
// ==========================================
// Gap lengths
`define FCP_GAP2_STD 8'h16
`define FCP_GAP2_PERP 8'h29
// ==========================================
// Reset values
`define FCP_FIFO_EN_N_DEF 1'b1
`define FCP_FIFO_THR_DEF 4'h0
`define FCP_PRECOMP_START_TRACK_DEF 8'h00
`define FCP_CYL_DEF 8'h00
`define FCP_GPL_DEF 8'h00
`define FCP_DTL_DEF 8'hff
`define FCP_EOT_DEF 8'h00
`define FCP_HLT_DEF 7'h00
`define FCP_HUT_DEF 4'h0
`define FCP_DRIVE_DEF 4'h0
`endif

// >>> fcp_pkg.sv
`default_nettype none
`include "fcp_cfg.svh"
package fcp_pkg;
  // ==========================================
  // Head loading states, Gray along idle-settle-loaded-release
  typedef enum logic [1:0] {
    FCP_HD_IDLE = 2'b00,
    FCP_HD_SETTLE = 2'b01,
    FCP_HD_LOADED = 2'b11,
    FCP_HD_RELEASE = 2'b10
  } fcp_head_state_t;

  // Sector length in bytes from the size code
  function automatic logic [14:0] fcp_sector_len(input logic [7:0] code);
    logic [2:0] sh;
    sh = (code > `FCP_SIZE_CODE_MAX) ? 3'(`FCP_SIZE_CODE_MAX) : code[2:0];
    return `FCP_SECTOR_BASE << sh;
  endfunction
endpackage
`default_nettype wire

// >>> fcp_head_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fcp_head_if;
  logic op_req;
  logic exec_end;
  logic [6:0] settle_intv;
  logic [3:0] release_intv;
  logic head_load;
  logic head_ready;
  modport ctl (output op_req, output exec_end, output settle_intv, output release_intv,
               input head_load, input head_ready);
  modport tmr (input op_req, input exec_end, input settle_intv, input release_intv,
               output head_load, output head_ready);
endinterface
`default_nettype wire

// >>> fcp_head_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcp_cfg.svh"
module fcp_head_timer
  import fcp_pkg::*;
#(
  parameter int SETTLE_UNIT_CYC = `FCP_SETTLE_UNIT_NS / `FCP_CLK_PERIOD_NS,
  parameter int RELEASE_UNIT_CYC = `FCP_RELEASE_UNIT_NS / `FCP_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  fcp_head_if.tmr hd
);
  fcp_head_state_t state;
  logic [23:0] unit_cnt;
  logic [6:0] intv_cnt;
  logic unit_tick;

  // ==========================================
  // Unit prescaler, restarted on each state change
  assign unit_tick = (state == FCP_HD_SETTLE) ? (unit_cnt == 24'(SETTLE_UNIT_CYC - 1))
                                              : (unit_cnt == 24'(RELEASE_UNIT_CYC - 1));
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unit_cnt <= '0;
    end else if (clk_en) begin
      if (state == FCP_HD_IDLE || state == FCP_HD_LOADED || unit_tick) begin
        unit_cnt <= '0;
      end else begin
        unit_cnt <= unit_cnt + 24'h000001;
      end
    end
  end

  // Head state machine with interval counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= FCP_HD_IDLE;
      intv_cnt <= '0;
      hd.head_load <= 1'b0;
      hd.head_ready <= 1'b0;
    end else if (clk_en) begin
      case (state)
        FCP_HD_IDLE: begin
          if (hd.op_req) begin
            hd.head_load <= 1'b1;
            intv_cnt <= hd.settle_intv;
            state <= FCP_HD_SETTLE;
          end
        end
        FCP_HD_SETTLE: begin
          // Wait out the settle interval before any transfer R4
          if (intv_cnt == 7'h00) begin
            hd.head_ready <= 1'b1;
            state <= FCP_HD_LOADED;
          end else if (unit_tick) begin
            intv_cnt <= intv_cnt - 7'h01;
          end
        end
        FCP_HD_LOADED: begin
          if (hd.exec_end) begin
            intv_cnt <= {3'h0, hd.release_intv};
            state <= FCP_HD_RELEASE;
          end
        end
        FCP_HD_RELEASE: begin
          // Unload once the release interval has run out R5
          if (hd.op_req) begin
            state <= FCP_HD_LOADED;
          end else if (intv_cnt == 7'h00) begin
            hd.head_load <= 1'b0;
            hd.head_ready <= 1'b0;
            state <= FCP_HD_IDLE;
          end else if (unit_tick) begin
            intv_cnt <= intv_cnt - 7'h01;
          end
        end
        default: begin
          state <= FCP_HD_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Checks
  a_ready_needs_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    hd.head_ready |-> hd.head_load) else $error("Head ready without head loaded"); // R4
  a_settle_zero_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && state == FCP_HD_SETTLE && intv_cnt == 7'h00) |=> hd.head_ready)
    else $error("Settle expiry did not make head ready"); // R4
  a_release_unload: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && state == FCP_HD_RELEASE && intv_cnt == 7'h00 && !hd.op_req) |=> !hd.head_load)
    else $error("Head not unloaded after release interval"); // R5
  a_release_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == FCP_HD_RELEASE && intv_cnt != 7'h00) |-> hd.head_load)
    else $error("Head unloaded before release interval ran out"); // R5
endmodule // fcp_head_timer
`default_nettype wire

// >>> fcp_param_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcp_cfg.svh"
// Contract
// R1: Perpendicular mode with the gap parameter set selects the perpendicular gap 2 length.
// R2: Sector spacing length parameter drives the gap 3 length.
// R3: Head address bit picks disk side 0 or 1.
// R4: After head load wait the settle interval before read or write.
// R5: Unload head after release interval from end of execution.
// R6: Lock keeps fifo enable, threshold, precomp track across software reset.
// R7: Density bit one selects MFM, zero selects FM.
// R8: Multi-track runs head 0 sectors then continues with head 1 sector one.
// R9: Nonzero size code gives 128 times two to the code, up to code 07.
// R10: Size code 00 means 128-byte sectors, transfer length from special length.
// R11: Host avoids size combinations the drive cannot support.
// R12: Host always writes zero in the no-DMA flag.
// R13: Perpendicular drive bits change only when overwrite enable is one.
// R14: Sense interrupt reports current head cylinder as present cylinder.
// R15: Target cylinder is the seek destination.
// R16: Polling disable set stops drive polling; clear lets it run.
// R17: With size code zero, bytes past special length are discarded or zero-filled.
// R18: FIFO enable is active low, disabled by default.
// R19: Command parameters are latched and held through execution.
module fcp_param_decode
  import fcp_pkg::*;
#(
  parameter int SETTLE_UNIT_CYC = `FCP_SETTLE_UNIT_NS / `FCP_CLK_PERIOD_NS,
  parameter int RELEASE_UNIT_CYC = `FCP_RELEASE_UNIT_NS / `FCP_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic rw_load,
  input wire logic rw_multi_head_track_flag,
  input wire logic rw_mfm,
  input wire logic rw_head_address,
  input wire logic [7:0] rw_sector,
  input wire logic [7:0] rw_size_code,
  input wire logic [7:0] rw_end_of_track,
  input wire logic [7:0] rw_sector_spacing_length,
  input wire logic [7:0] rw_special_sector_length,
  input wire logic exec_end,
  input wire logic sector_end,
  input wire logic data_byte,
  input wire logic specify_load,
  input wire logic [6:0] sp_head_settle_interval,
  input wire logic [3:0] sp_head_release_interval,
  input wire logic sp_no_dma_flag,
  input wire logic configure_load,
  input wire logic cf_poll_disable,
  input wire logic cf_fifo_enable_n,
  input wire logic [3:0] cf_fifo_threshold,
  input wire logic [7:0] cf_precomp_start_track,
  input wire logic lock_load,
  input wire logic lk_lock,
  input wire logic lk_overwrite_enable,
  input wire logic perp_load,
  input wire logic pp_gap,
  input wire logic pp_wgate,
  input wire logic [3:0] pp_drive_bits,
  input wire logic seek_load,
  input wire logic [7:0] target_cylinder,
  input wire logic step_tick,
  input wire logic sense_int,
  input wire logic soft_reset,
  output logic exec_busy,
  output logic mfm_mode,
  output logic multi_head_track_flag,
  output logic [7:0] gap2_len,
  output logic [7:0] gap3_len,
  output logic head_sel,
  output logic [7:0] cur_sector,
  output logic track_done,
  output logic [14:0] sector_len,
  output logic [14:0] xfer_len,
  output logic byte_keep,
  output logic head_load,
  output logic head_ready,
  output logic poll_enable,
  output logic fifo_enable_n,
  output logic [3:0] fifo_threshold,
  output logic [7:0] precomp_start_track,
  output logic lock,
  output logic overwrite_enable,
  output logic [3:0] perp_drive_bits,
  output logic step_out,
  output logic step_dir,
  output logic [7:0] present_cylinder
);
  fcp_head_if hd ();
  logic gap_sel;
  logic wgate;
  logic [6:0] settle_intv;
  logic [3:0] release_intv;
  logic [7:0] end_of_track;
  logic [7:0] cur_cyl;
  logic [7:0] seek_dest;
  logic [14:0] byte_cnt;
  logic perp_active;
  logic rw_take;

  // ==========================================
  // Head timer connection
  assign rw_take = rw_load && !exec_busy;
  assign hd.op_req = rw_take;
  assign hd.exec_end = exec_end && exec_busy;
  assign hd.settle_intv = settle_intv;
  assign hd.release_intv = release_intv;
  assign head_load = hd.head_load;
  assign head_ready = hd.head_ready;
  fcp_head_timer #(
    .SETTLE_UNIT_CYC(SETTLE_UNIT_CYC),
    .RELEASE_UNIT_CYC(RELEASE_UNIT_CYC)
  ) u_head_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .hd(hd.tmr)
  );

  // ==========================================
  // Read/write parameters, taken only while idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      exec_busy <= 1'b0;
      mfm_mode <= 1'b0;
      multi_head_track_flag <= 1'b0;
      gap3_len <= `FCP_GPL_DEF;
      end_of_track <= `FCP_EOT_DEF;
      sector_len <= `FCP_SECTOR_BASE;
      xfer_len <= `FCP_SECTOR_BASE;
    end else if (clk_en) begin
      if (rw_take) begin
        exec_busy <= 1'b1; // R19
        mfm_mode <= rw_mfm; // R7
        multi_head_track_flag <= rw_multi_head_track_flag;
        gap3_len <= rw_sector_spacing_length; // R2
        end_of_track <= rw_end_of_track;
        sector_len <= fcp_sector_len(rw_size_code); // R9
        // Size code zero limits the transfer to the special length R10
        xfer_len <= (rw_size_code == `FCP_SIZE_CODE_ZERO) ? {7'h00, rw_special_sector_length}
                                                        : fcp_sector_len(rw_size_code); // R10
      end else if (exec_end) begin
        exec_busy <= 1'b0;
      end
    end
  end

  // Head and sector walk across the cylinder
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      head_sel <= `FCP_HEAD0;
      cur_sector <= `FCP_FIRST_SECTOR;
      track_done <= 1'b0;
    end else if (clk_en) begin
      track_done <= 1'b0;
      if (rw_take) begin
        head_sel <= rw_head_address; // R3
        cur_sector <= rw_sector;
      end else if (exec_busy && sector_end) begin
        if (cur_sector != end_of_track) begin
          cur_sector <= cur_sector + 8'h01;
        end else if (multi_head_track_flag && head_sel == `FCP_HEAD0) begin
          head_sel <= `FCP_HEAD1; // R8
          cur_sector <= `FCP_FIRST_SECTOR; // R8
        end else begin
          track_done <= 1'b1;
        end
      end
    end
  end

  // Byte filter: bytes past the transfer length are dropped or padded downstream
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      byte_cnt <= '0;
      byte_keep <= 1'b0;
    end else if (clk_en) begin
      if (rw_take || sector_end) begin
        byte_cnt <= '0;
        byte_keep <= 1'b0;
      end else if (data_byte) begin
        byte_keep <= (byte_cnt < xfer_len); // R17
        byte_cnt <= byte_cnt + 15'h0001;
      end else begin
        byte_keep <= 1'b0;
      end
    end
  end

  // ==========================================
  // Head timing set by the specify parameters; no-DMA flag is assumed zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      settle_intv <= `FCP_HLT_DEF;
      release_intv <= `FCP_HUT_DEF;
    end else if (clk_en && specify_load && !exec_busy) begin
      settle_intv <= sp_head_settle_interval; // R4
      release_intv <= sp_head_release_interval; // R5
    end
  end

  // Configure settings; software reset restores the FIFO and precomp ones, not polling, unless locked
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      poll_enable <= 1'b1;
      fifo_enable_n <= `FCP_FIFO_EN_N_DEF; // R18
      fifo_threshold <= `FCP_FIFO_THR_DEF;
      precomp_start_track <= `FCP_PRECOMP_START_TRACK_DEF;
    end else if (clk_en) begin
      // Software reset wins over a configure in the same cycle
      if (soft_reset) begin
        if (!lock) begin
          fifo_enable_n <= `FCP_FIFO_EN_N_DEF; // R6
          fifo_threshold <= `FCP_FIFO_THR_DEF; // R6
          precomp_start_track <= `FCP_PRECOMP_START_TRACK_DEF; // R6
        end
      end else if (configure_load && !exec_busy) begin
        poll_enable <= !cf_poll_disable; // R16
        fifo_enable_n <= cf_fifo_enable_n; // R18
        fifo_threshold <= cf_fifo_threshold;
        precomp_start_track <= cf_precomp_start_track;
      end
    end
  end

  // Lock and overwrite flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock <= 1'b0;
      overwrite_enable <= 1'b0;
    end else if (clk_en && lock_load && !exec_busy) begin
      lock <= lk_lock;
      overwrite_enable <= lk_overwrite_enable;
    end
  end

  // Perpendicular mode; drive bits guarded by the overwrite flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap_sel <= 1'b0;
      wgate <= 1'b0;
      perp_drive_bits <= `FCP_DRIVE_DEF;
    end else if (clk_en && perp_load && !exec_busy) begin
      gap_sel <= pp_gap;
      wgate <= pp_wgate;
      if (overwrite_enable) begin
        perp_drive_bits <= pp_drive_bits; // R13
      end
    end
  end

  // Gap 2 length follows perpendicular mode
  assign perp_active = wgate || perp_drive_bits[0];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap2_len <= `FCP_GAP2_STD;
    end else if (clk_en) begin
      gap2_len <= (perp_active && gap_sel) ? `FCP_GAP2_PERP : `FCP_GAP2_STD; // R1
    end
  end

  // ==========================================
  // Seek toward the target cylinder, one step per tick
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seek_dest <= `FCP_CYL_DEF;
      cur_cyl <= `FCP_CYL_DEF;
      step_out <= 1'b0;
      step_dir <= 1'b0;
    end else if (clk_en) begin
      step_out <= 1'b0;
      if (seek_load && !exec_busy) begin
        seek_dest <= target_cylinder; // R15
      end else if (step_tick && cur_cyl != seek_dest) begin
        step_out <= 1'b1;
        step_dir <= (seek_dest > cur_cyl);
        cur_cyl <= (seek_dest > cur_cyl) ? cur_cyl + 8'h01 : cur_cyl - 8'h01; // R15
      end
    end
  end

  // Present cylinder captured on sense interrupt
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      present_cylinder <= `FCP_CYL_DEF;
    end else if (clk_en && sense_int) begin
      present_cylinder <= cur_cyl; // R14
    end
  end

  // ==========================================
  // Checks
  sequence s_load_idle;
    clk_en && rw_load && !exec_busy;
  endsequence
  a_density_taken: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_load_idle |=> (mfm_mode == $past(rw_mfm) && head_sel == $past(rw_head_address)))
    else $error("Density or head not taken from parameters"); // R7
  a_gap3_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (exec_busy && $stable(exec_busy)) |-> $stable(gap3_len)) else $error("Gap 3 changed mid command"); // R19
  a_gap3_taken: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_load_idle |=> gap3_len == $past(rw_sector_spacing_length)) else $error("Gap 3 not taken"); // R2
  a_size_zero_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_load_idle and rw_size_code == 8'h00) |=> (sector_len == 15'h0080 && xfer_len[14:8] == 7'h00))
    else $error("Size code zero lengths wrong"); // R10
  a_size_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_load_idle and rw_size_code == 8'h03) |=> sector_len == 15'h0400) else $error("Sector length wrong"); // R9
  a_mt_head_swap: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && exec_busy && sector_end && !rw_load && cur_sector == end_of_track && multi_head_track_flag
     && head_sel == 1'b0) |=> (head_sel && cur_sector == 8'h01)) else $error("Multi-track swap failed"); // R8
  a_perp_guard: assert property (@(posedge ref_clk) disable iff (!nrst)
    !overwrite_enable |=> $stable(perp_drive_bits)) else $error("Drive bits changed without overwrite"); // R13
  a_lock_keeps: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && soft_reset && lock) |=> $stable(fifo_threshold) && $stable(precomp_start_track))
    else $error("Locked settings lost on software reset"); // R6
  a_soft_reset_def: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && soft_reset && !lock) |=> (fifo_enable_n && fifo_threshold == 4'h0))
    else $error("Software reset did not restore defaults"); // R6
  a_poll_ctl: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && configure_load && !exec_busy && !soft_reset) |=> poll_enable == !$past(cf_poll_disable))
    else $error("Polling control wrong"); // R16
  a_pcn_report: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && sense_int) |=> present_cylinder == $past(cur_cyl)) else $error("Present cylinder wrong"); // R14
  a_byte_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && data_byte && !rw_take && !sector_end && byte_cnt >= xfer_len) |=> !byte_keep)
    else $error("Byte past transfer length kept"); // R17
  a_gap2_perp: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && perp_active && gap_sel) |=> gap2_len == 8'h29) else $error("Gap 2 not perpendicular"); // R1
endmodule // fcp_param_decode
`default_nettype wire

// >>> fcp_drive_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Drive side: step-rate ticks and head carriage position
module fcp_drive_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic step_out,
  input wire logic step_dir,
  output logic step_tick,
  output logic [7:0] pos
);
  logic [1:0] div;

  // Step permission every fourth cycle, as a slow drive would give
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div <= 2'h0;
      step_tick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      step_tick <= (div == 2'h3);
    end
  end

  // Carriage moves one cylinder per step pulse, in the pulse's direction
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pos <= 8'h00;
    end else if (step_out) begin
      pos <= step_dir ? pos + 8'h01 : pos - 8'h01;
    end
  end
endmodule // fcp_drive_model
`default_nettype wire

// >>> fcp_param_decode_test.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_param_decode_test;
  import fcp_pkg::*;
  localparam int RW = 0, XE = 1, SE = 2, DB = 3, SP = 4, CF = 5, LK = 6, PP = 7, SK = 8, SI = 9, SR = 10;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [10:0] stb = 11'h000;
  logic mt = 1'b0, mfm = 1'b0, hd = 1'b0, poll_dis = 1'b0, fen = 1'b1, lk = 1'b0, ow = 1'b0, pgap = 1'b0;
  logic wg = 1'b0, en = 1'b1;
  logic [7:0] sec = 8'h01, code = 8'h00, eot = 8'h01, sector_spacing_length = 8'h00, special_sector_length = 8'hff, pre = 8'h00, tgt = 8'h00;
  logic [6:0] head_settle_interval = 7'h00;
  logic [3:0] head_release_interval = 4'h0, thr = 4'h0, pbits = 4'h0;
  logic exec_busy, mfm_mode, mtf, head_sel, byte_keep, head_load, head_ready, poll_enable, fifo_enable_n;
  logic lock, overwrite_enable, step_out, step_dir, step_tick, kept, done, trk_done;
  logic [7:0] gap2_len, gap3_len, cur_sector, precomp_start_track, present_cylinder, pos;
  logic [14:0] sector_len, xfer_len;
  logic [3:0] fifo_threshold, perp_drive_bits;
  int mismatches = 0;
  int samples_checked = 0;

  // ==========================================
  // Clock, design and drive model
  always #5 ref_clk = ~ref_clk;

  fcp_param_decode #(.SETTLE_UNIT_CYC(4), .RELEASE_UNIT_CYC(8)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(en), .rw_load(stb[RW]), .rw_multi_head_track_flag(mt),
    .rw_mfm(mfm), .rw_head_address(hd), .rw_sector(sec), .rw_size_code(code), .rw_end_of_track(eot),
    .rw_sector_spacing_length(sector_spacing_length), .rw_special_sector_length(special_sector_length), .exec_end(stb[XE]),
    .sector_end(stb[SE]), .data_byte(stb[DB]), .specify_load(stb[SP]), .sp_head_settle_interval(head_settle_interval),
    .sp_head_release_interval(head_release_interval), .sp_no_dma_flag(1'b0), .configure_load(stb[CF]),
    .cf_poll_disable(poll_dis), .cf_fifo_enable_n(fen), .cf_fifo_threshold(thr),
    .cf_precomp_start_track(pre), .lock_load(stb[LK]), .lk_lock(lk), .lk_overwrite_enable(ow),
    .perp_load(stb[PP]), .pp_gap(pgap), .pp_wgate(wg), .pp_drive_bits(pbits), .seek_load(stb[SK]),
    .target_cylinder(tgt), .step_tick(step_tick), .sense_int(stb[SI]), .soft_reset(stb[SR]),
    .exec_busy(exec_busy), .mfm_mode(mfm_mode), .multi_head_track_flag(mtf), .gap2_len(gap2_len),
    .gap3_len(gap3_len), .head_sel(head_sel), .cur_sector(cur_sector), .track_done(trk_done),
    .sector_len(sector_len), .xfer_len(xfer_len), .byte_keep(byte_keep), .head_load(head_load),
    .head_ready(head_ready), .poll_enable(poll_enable), .fifo_enable_n(fifo_enable_n),
    .fifo_threshold(fifo_threshold), .precomp_start_track(precomp_start_track), .lock(lock),
    .overwrite_enable(overwrite_enable), .perp_drive_bits(perp_drive_bits), .step_out(step_out),
    .step_dir(step_dir), .present_cylinder(present_cylinder));

  fcp_drive_model drive (.ref_clk(ref_clk), .nrst(nrst), .step_out(step_out), .step_dir(step_dir),
    .step_tick(step_tick), .pos(pos));

  // ==========================================
  // Access tasks
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One-cycle strobe, then let outputs settle; notes any byte_keep or track_done pulse
  task automatic strobe(input int k);
    kept = 1'b0;
    done = 1'b0;
    stb[k] = 1'b1;
    step(1);
    stb = 11'h000;
    repeat (3) begin
      kept = kept | byte_keep;
      done = done | trk_done;
      step(1);
    end
  endtask

  task automatic rw_issue(input logic m, f, h, input logic [7:0] s, c, e, g, d);
    {mt, mfm, hd, sec, code, eot, sector_spacing_length, special_sector_length} = {m, f, h, s, c, e, g, d};
    strobe(RW);
  endtask

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait on head_ready (sel=1) or head_load (sel=0)
  task automatic wait_head(input logic sel, input logic lvl);
    int n;
    n = 0;
    while (((sel ? head_ready : head_load) !== lvl) && n < 40) begin
      step(1);
      n++;
    end
    if (n == 40) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic seek_to(input logic [7:0] t);
    int n;
    tgt = t;
    strobe(SK);
    n = 0;
    while (pos !== t && n < 80) begin
      step(1);
      n++;
    end
    if (pos !== t) begin
      mismatches++;
      report_and_stop();
    end
    step(2);
    strobe(SI);
    chk(present_cylinder, t);
    chk(pos, t);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================
  // Test sequence
  initial begin
    step(6);
    nrst = 1'b1;
    step(1);
    chk(fifo_enable_n, 1'b1);
    chk(poll_enable, 1'b1);
    chk(gap2_len, 8'h16);
    // Head settle, parameter hold while busy, then release
    head_settle_interval = 7'h02;
    head_release_interval = 4'h1;
    strobe(SP);
    rw_issue(1'b0, 1'b1, 1'b0, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff);
    chk(exec_busy, 1'b1);
    chk(head_load, 1'b1);
    chk(head_ready, 1'b0);
    thr = 4'h9;
    strobe(CF);
    chk(fifo_threshold, 4'h0);
    wait_head(1'b1, 1'b1);
    chk(head_ready, 1'b1);
    strobe(XE);
    chk(exec_busy, 1'b0);
    chk(head_load, 1'b1);
    wait_head(1'b0, 1'b0);
    chk(head_ready, 1'b0);
    // Size codes 00 to 07, each density and side; codes kept to ones a drive supports
    for (int c = 0; c < 8; c++) begin
      rw_issue(1'b0, c[0], c[1], 8'h01, 8'(c), 8'h09, 8'h1b + 8'(c), 8'h40);
      chk(sector_len, 15'h0080 << c);
      chk(xfer_len, (c == 0) ? 15'h0040 : 15'h0080 << c);
      chk(mfm_mode, c[0]);
      chk(head_sel, c[1]);
      chk(gap3_len, 15'h001b + 15'(c));
      strobe(XE);
    end
    // Multi-track continues on head 1 at the first sector
    rw_issue(1'b1, 1'b1, 1'b0, 8'h01, 8'h02, 8'h02, 8'h1b, 8'hff);
    chk(mtf, 1'b1);
    strobe(SE);
    chk(cur_sector, 8'h02);
    strobe(SE);
    chk(head_sel, 1'b1);
    chk(cur_sector, 8'h01);
    strobe(SE);
    chk(done, 1'b0);
    strobe(SE);
    chk(done, 1'b1);
    strobe(XE);
    // Size code zero with a two-byte special length
    rw_issue(1'b0, 1'b1, 1'b0, 8'h01, 8'h00, 8'h09, 8'h1b, 8'h02);
    for (int b = 0; b < 3; b++) begin
      strobe(DB);
      chk(kept, b < 2);
    end
    strobe(XE);
    // Configure, lock and software reset
    {poll_dis, fen, thr, pre} = {1'b1, 1'b0, 4'h5, 8'h22};
    strobe(CF);
    chk(poll_enable, 1'b0);
    chk(fifo_enable_n, 1'b0);
    lk = 1'b1;
    strobe(LK);
    chk(lock, 1'b1);
    strobe(SR);
    chk(fifo_threshold, 4'h5);
    chk(precomp_start_track, 8'h22);
    chk(fifo_enable_n, 1'b0);
    lk = 1'b0;
    strobe(LK);
    strobe(SR);
    chk(fifo_threshold, 4'h0);
    chk(precomp_start_track, 8'h00);
    chk(fifo_enable_n, 1'b1);
    chk(poll_enable, 1'b0);
    poll_dis = 1'b0;
    strobe(CF);
    chk(poll_enable, 1'b1);
    // Clock enable low freezes the polling setting against a configure
    en = 1'b0;
    poll_dis = 1'b1;
    strobe(CF);
    chk(poll_enable, 1'b1);
    {en, poll_dis} = {1'b1, 1'b0};
    // Perpendicular drive bits guarded by overwrite enable
    {pbits, pgap} = {4'h1, 1'b1};
    strobe(PP);
    chk(perp_drive_bits, 4'h0);
    chk(gap2_len, 8'h16);
    ow = 1'b1;
    strobe(LK);
    chk(overwrite_enable, 1'b1);
    strobe(PP);
    chk(perp_drive_bits, 4'h1);
    chk(gap2_len, 8'h29);
    pgap = 1'b0;
    strobe(PP);
    chk(gap2_len, 8'h16);
    // Write gate alone also marks perpendicular mode
    {pbits, pgap, wg} = {4'h0, 1'b1, 1'b1};
    strobe(PP);
    chk(perp_drive_bits, 4'h0);
    chk(gap2_len, 8'h29);
    // Seek out and back
    seek_to(8'h03);
    seek_to(8'h01);
    report_and_stop();
  end
endmodule // fcp_param_decode_test
`default_nettype wire
